// ### include/sadbb_regs.svh
// address map, sizes and field positions of the system address decoder
`ifndef SADBB_REGS_SVH
`define SADBB_REGS_SVH
`define SADBB_FLASH_LO    32'h0000_0000
`define SADBB_FLASH_HI    32'h07FF_FFFF
`define SADBB_FLASH_SIZE  32'h0002_0000
`define SADBB_FALIAS_LO   32'h3000_0000
`define SADBB_FALIAS_HI   32'h33FF_FFFF
`define SADBB_SRAML_LO    32'h1C00_0000
`define SADBB_SRAMU_LO    32'h2000_0000
`define SADBB_SRAMU_HI    32'h200F_FFFF
`define SADBB_SRAML_SIZE  32'h0000_4000
`define SADBB_SRAMU_SIZE  32'h0000_4000
`define SADBB_SALIAS_LO   32'h2200_0000
`define SADBB_SALIAS_HI   32'h23FF_FFFF
`define SADBB_PB_LO       32'h4000_0000
`define SADBB_PB_HI       32'h4007_FFFF
`define SADBB_GPIO_LO     32'h400F_F000
`define SADBB_GPIO_HI     32'h400F_FFFF
`define SADBB_PALIAS_LO   32'h4200_0000
`define SADBB_PALIAS_HI   32'h42FF_FFFF
`define SADBB_GALIAS_LO   32'h43FE_0000
`define SADBB_GALIAS_HI   32'h43FF_FFFF
`define SADBB_PPB_LO      32'hE000_0000
`define SADBB_PPB_HI      32'hE00F_FFFF
`define SADBB_BB_SHIFT    5
`define SADBB_WORD_MASK   32'hFFFF_FFFC
`define SADBB_BIT_HI      6
`define SADBB_BIT_LO      2
`define SADBB_RD_ONE      32'h0000_0001
`define SADBB_RD_ZERO     32'h0000_0000
`endif

// ### include/sadbb_pkg.sv
// types shared by the system address decoder
package sadbb_pkg;
   typedef enum logic [1:0] {
      SADBB_M_CORE  = 2'h0,
      SADBB_M_DEBUG = 2'h1,
      SADBB_M_DMA   = 2'h2,
      SADBB_M_OTHER = 2'h3
   } sadbb_master_e;

   typedef enum logic [2:0] {
      SADBB_T_NONE  = 3'h0,
      SADBB_T_FLASH = 3'h1,
      SADBB_T_SRAM  = 3'h2,
      SADBB_T_PB    = 3'h3,
      SADBB_T_GPIO  = 3'h4,
      SADBB_T_PPB   = 3'h5
   } sadbb_tgt_e;

   typedef struct packed {
      sadbb_master_e master;
      logic          write;
      logic [31:0]   addr;
      logic [31:0]   wdata;
   } sadbb_req_s;

   typedef struct packed {
      logic          err;
      logic [31:0]   rdata;
   } sadbb_rsp_s;

   typedef struct packed {
      sadbb_tgt_e    tgt;
      logic          write;
      logic [31:0]   addr;
      logic [31:0]   wdata;
   } sadbb_slv_s;

   typedef struct packed {
      sadbb_tgt_e    tgt;
      logic          err;
      logic          alias_hit;
      logic [31:0]   addr;
      logic [4:0]    bitn;
   } sadbb_dec_s;
endpackage

// ### rtl/sadbb_top.sv
// system address decoder with bit-band alias translation
`timescale 1ns/10ps
`include "sadbb_regs.svh"
module sadbb_top (
   input  wire logic                 MCLK,
   input  wire logic                 RST_B,
   input  wire logic                 REQ_VALID,
   input  wire sadbb_pkg::sadbb_req_s REQ,
   output logic                      REQ_READY,
   output logic                      RSP_VALID,
   output sadbb_pkg::sadbb_rsp_s     RSP,
   input  wire logic                 FLASH_CMD_BUSY,
   output logic                      SLV_VALID,
   output logic                      SLV_LOCK,
   output sadbb_pkg::sadbb_slv_s     SLV_REQ,
   input  wire logic                 SLV_ACK,
   input  wire logic                 SLV_ERR,
   input  wire logic [31:0]          SLV_RDATA
);

   // ----------------------------------------
   // state and helpers
   // ----------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ACC  = 5'b00010,
      ST_BRD  = 5'b00100,
      ST_BWR  = 5'b01000,
      ST_RSP  = 5'b10000
   } sadbb_state_e;

   sadbb_state_e          state_r, state_nxt;
   sadbb_pkg::sadbb_dec_s dec_r,   dec_nxt;
   sadbb_pkg::sadbb_slv_s slv_r,   slv_nxt;
   sadbb_pkg::sadbb_rsp_s rsp_r,   rsp_nxt;
   logic                  bval_r,  bval_nxt;
   sadbb_pkg::sadbb_dec_s dec_now;

   function automatic logic in_rng(input logic [31:0] a,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   // each alias word maps to one bit: word = tbase + (offset/32 rounded to a word)
   function automatic logic [31:0] bb_word(input logic [31:0] a,
                                           input logic [31:0] abase,
                                           input logic [31:0] tbase);
      bb_word = tbase + (((a - abase) >> `SADBB_BB_SHIFT) & `SADBB_WORD_MASK);
   endfunction

   function automatic sadbb_pkg::sadbb_dec_s dec_addr(input logic [31:0] a,
                                                      input sadbb_pkg::sadbb_master_e m,
                                                      input logic wr,
                                                      input logic fbusy);
      sadbb_pkg::sadbb_dec_s d;
      logic                  priv;
      logic                  pb_ok;
      logic [31:0]           foff;
      // default answer: reserved space ends in error
      d.tgt       = sadbb_pkg::SADBB_T_NONE;
      d.err       = 1'b1;
      d.alias_hit = 1'b0;
      d.addr      = a;
      d.bitn      = a[`SADBB_BIT_HI:`SADBB_BIT_LO];
      priv  = (m == sadbb_pkg::SADBB_M_CORE) || (m == sadbb_pkg::SADBB_M_DEBUG);
      pb_ok = priv || (m == sadbb_pkg::SADBB_M_DMA);
      foff  = a - `SADBB_FALIAS_LO;
      if (in_rng(a, `SADBB_FLASH_LO, `SADBB_FLASH_HI)) begin
         d.tgt = sadbb_pkg::SADBB_T_FLASH;
         d.err = (a >= `SADBB_FLASH_SIZE) || (!wr && fbusy);
      end else if (in_rng(a, `SADBB_FALIAS_LO, `SADBB_FALIAS_HI) && priv) begin
         d.tgt  = sadbb_pkg::SADBB_T_FLASH;
         d.addr = foff;
         d.err  = (foff >= `SADBB_FLASH_SIZE) || (!wr && fbusy);
      end else if (in_rng(a, `SADBB_SRAML_LO, `SADBB_SRAMU_HI)) begin
         d.tgt = sadbb_pkg::SADBB_T_SRAM;
         d.err = !in_rng(a, `SADBB_SRAMU_LO - `SADBB_SRAML_SIZE,
                         `SADBB_SRAMU_LO + `SADBB_SRAMU_SIZE - 32'h1);
      end else if (in_rng(a, `SADBB_SALIAS_LO, `SADBB_SALIAS_HI) && priv) begin
         d.tgt       = sadbb_pkg::SADBB_T_SRAM;
         d.alias_hit = 1'b1;
         d.addr      = bb_word(a, `SADBB_SALIAS_LO, `SADBB_SRAMU_LO);
         d.err       = d.addr >= (`SADBB_SRAMU_LO + `SADBB_SRAMU_SIZE);
      end else if (in_rng(a, `SADBB_PB_LO, `SADBB_PB_HI) && pb_ok) begin
         d.tgt = sadbb_pkg::SADBB_T_PB;
         d.err = 1'b0;
      end else if (in_rng(a, `SADBB_GPIO_LO, `SADBB_GPIO_HI) && pb_ok) begin
         d.tgt = sadbb_pkg::SADBB_T_GPIO;
         d.err = 1'b0;
      end else if (in_rng(a, `SADBB_PALIAS_LO, `SADBB_PALIAS_HI) && priv) begin
         d.tgt       = sadbb_pkg::SADBB_T_PB;
         d.alias_hit = 1'b1;
         d.addr      = bb_word(a, `SADBB_PALIAS_LO, `SADBB_PB_LO);
         d.err       = 1'b0;
      end else if (in_rng(a, `SADBB_GALIAS_LO, `SADBB_GALIAS_HI) && priv) begin
         d.tgt       = sadbb_pkg::SADBB_T_GPIO;
         d.alias_hit = 1'b1;
         d.addr      = bb_word(a, `SADBB_GALIAS_LO, `SADBB_GPIO_LO);
         d.err       = 1'b0;
      end else if (in_rng(a, `SADBB_PPB_LO, `SADBB_PPB_HI) && priv) begin
         d.tgt = sadbb_pkg::SADBB_T_PPB;
         d.err = 1'b0;
      end
      dec_addr = d;
   endfunction

   // ----------------------------------------
   // transfer sequencer
   // ----------------------------------------
   assign dec_now   = dec_addr(REQ.addr, REQ.master, REQ.write, FLASH_CMD_BUSY);
   assign REQ_READY = (state_r == ST_IDLE);
   assign RSP_VALID = (state_r == ST_RSP);
   assign RSP       = rsp_r;
   assign SLV_REQ   = slv_r;
   assign SLV_VALID = (state_r == ST_ACC) || (state_r == ST_BRD) || (state_r == ST_BWR);
   // lock keeps other masters off the target word between the read and the write
   assign SLV_LOCK  = (state_r == ST_BRD) || (state_r == ST_BWR);

   always_comb begin
      state_nxt = state_r;
      dec_nxt   = dec_r;
      slv_nxt   = slv_r;
      rsp_nxt   = rsp_r;
      bval_nxt  = bval_r;
      case (state_r)
         ST_IDLE: begin
            if (REQ_VALID) begin
               dec_nxt       = dec_now;
               bval_nxt      = REQ.wdata[0];
               slv_nxt.tgt   = dec_now.tgt;
               slv_nxt.addr  = dec_now.addr;
               slv_nxt.write = REQ.write && !dec_now.alias_hit;
               slv_nxt.wdata = REQ.wdata;
               if (dec_now.err) begin
                  rsp_nxt   = '{err: 1'b1, rdata: `SADBB_RD_ZERO};
                  state_nxt = ST_RSP;
               end else if (dec_now.alias_hit) begin
                  state_nxt = ST_BRD;
               end else begin
                  state_nxt = ST_ACC;
               end
               if (dec_now.alias_hit) begin
                  dec_nxt.alias_hit = REQ.write;
               end
            end
         end
         ST_ACC: begin
            if (SLV_ACK) begin
               rsp_nxt   = '{err: SLV_ERR, rdata: SLV_RDATA};
               state_nxt = ST_RSP;
            end
         end
         ST_BRD: begin
            if (SLV_ACK) begin
               if (SLV_ERR || !dec_r.alias_hit) begin
                  rsp_nxt.err   = SLV_ERR;
                  rsp_nxt.rdata = SLV_RDATA[dec_r.bitn] ? `SADBB_RD_ONE
                                                        : `SADBB_RD_ZERO;
                  state_nxt     = ST_RSP;
               end else begin
                  slv_nxt.write = 1'b1;
                  slv_nxt.wdata = SLV_RDATA;
                  slv_nxt.wdata[dec_r.bitn] = bval_r;
                  state_nxt     = ST_BWR;
               end
            end
         end
         ST_BWR: begin
            if (SLV_ACK) begin
               rsp_nxt   = '{err: SLV_ERR, rdata: `SADBB_RD_ZERO};
               state_nxt = ST_RSP;
            end
         end
         ST_RSP: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         state_r <= ST_IDLE;
         dec_r   <= '0;
         slv_r   <= '0;
         rsp_r   <= '0;
         bval_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         dec_r   <= dec_nxt;
         slv_r   <= slv_nxt;
         rsp_r   <= rsp_nxt;
         bval_r  <= bval_nxt;
      end
   end

endmodule

// ### tb/sadbb_top_checker.sv
// port assertions of the system address decoder
`timescale 1ns/10ps
`include "sadbb_regs.svh"
module sadbb_top_checker (
   input wire logic                  MCLK,
   input wire logic                  RST_B,
   input wire logic                  REQ_VALID,
   input wire sadbb_pkg::sadbb_req_s REQ,
   input wire logic                  REQ_READY,
   input wire logic                  RSP_VALID,
   input wire sadbb_pkg::sadbb_rsp_s RSP,
   input wire logic                  FLASH_CMD_BUSY,
   input wire logic                  SLV_VALID,
   input wire logic                  SLV_LOCK,
   input wire sadbb_pkg::sadbb_slv_s SLV_REQ,
   input wire logic                  SLV_ACK,
   input wire logic                  SLV_ERR,
   input wire logic [31:0]           SLV_RDATA
);
   // ----------------------------------------
   // take, error, master and address shorthands
   // ----------------------------------------
   logic        tk;
   logic        er;
   logic [1:0]  m;
   logic [31:0] a;
   assign tk = REQ_VALID && REQ_READY;
   assign er = RSP_VALID && RSP.err;
   assign m  = REQ.master;
   assign a  = REQ.addr;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   AST_RSV_ERR: assert property (tk && a inside {[32'h0800_0000:32'h1BFF_FFFF]} |-> ##[1:2] er)
      else $error("reserved space not refused");
   AST_FLASH_BEYOND: assert property (tk && a inside {[`SADBB_FLASH_SIZE:`SADBB_FLASH_HI]}
      |-> ##[1:2] er) else $error("flash beyond size not refused");
   AST_BUSY_RD: assert property (tk && !REQ.write && FLASH_CMD_BUSY
      && a < `SADBB_FLASH_SIZE |-> ##[1:2] er) else $error("flash collision not refused");
   AST_PPB_DMA: assert property (tk && m == 2'h2 && a inside {[`SADBB_PPB_LO:`SADBB_PPB_HI]}
      |-> ##[1:2] er) else $error("private space open to dma");
   AST_OTHER_PB: assert property (tk && m == 2'h3 && a inside {[`SADBB_PB_LO:`SADBB_PB_HI]}
      |-> ##[1:2] er) else $error("bridge open to other master");
   AST_FLASH_GO: assert property (tk && a < `SADBB_FLASH_SIZE && (REQ.write || !FLASH_CMD_BUSY)
      |=> SLV_VALID && SLV_REQ.tgt == 3'h1) else $error("flash not routed");
   AST_DEBUG_PPB: assert property (tk && m == 2'h1 && a inside {[`SADBB_PPB_LO:`SADBB_PPB_HI]}
      |=> SLV_VALID && SLV_REQ.tgt == 3'h5 && SLV_REQ.addr == $past(a))
      else $error("debug refused in private space");
   AST_ALIAS_MAP: assert property (tk && m == 2'h0 && a inside {[`SADBB_SALIAS_LO:32'h2207_FFFF]}
      |=> SLV_LOCK && SLV_REQ.tgt == 3'h2 && SLV_REQ.addr == `SADBB_SRAMU_LO
      + ((($past(a) - `SADBB_SALIAS_LO) >> 7) << 2)) else $error("alias word map");
   // the request must not move under a stalled slave
   AST_SLV_HOLD: assert property (SLV_VALID && !SLV_ACK |=> SLV_VALID && $stable(SLV_REQ))
      else $error("slave request moved before ack");
endmodule
bind sadbb_top sadbb_top_checker i_sadbb_top_checker (.MCLK, .RST_B, .REQ_VALID, .REQ,
   .REQ_READY, .RSP_VALID, .RSP, .FLASH_CMD_BUSY, .SLV_VALID, .SLV_LOCK, .SLV_REQ,
   .SLV_ACK, .SLV_ERR, .SLV_RDATA);

// ### tb/sadbb_slave_model.sv
// far-side memory slave with optional stall and bridge slot error
`timescale 1ns/10ps
module sadbb_slave_model (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic                  slow,
   input  wire logic                  vld,
   input  wire sadbb_pkg::sadbb_slv_s req,
   output logic                       ack,
   output logic                       err,
   output logic [31:0]                rdata
);
   logic [31:0] mem [logic [31:0]];
   logic [1:0]  cnt;
   // unwritten words read as address xor a fixed pattern
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack <= 1'b0;
         err <= 1'b0;
         rdata <= 32'h0;
         cnt <= 2'h0;
      end else begin
         ack <= 1'b0;
         err <= 1'b0;
         rdata <= ~rdata;
         if (vld && !ack) begin
            if (slow && cnt != 2'h3) begin
               cnt <= cnt + 2'h1;
            end else begin
               cnt <= 2'h0;
               ack <= 1'b1;
               err <= req.tgt == 3'h3 && req.addr[19:12] == 8'h00;
               if (req.write) begin
                  mem[req.addr] = req.wdata;
               end
               rdata <= mem.exists(req.addr) ? mem[req.addr] : req.addr ^ 32'h5A5A_A5A5;
            end
         end
      end
   end
endmodule

// ### tb/sadbb_top_tb.sv
// self-checking bench of the system address decoder
`timescale 1ns/10ps
`include "sadbb_regs.svh"
module sadbb_top_tb;
   logic                  MCLK = 1'b0;
   logic                  RST_B = 1'b0;
   logic                  REQ_VALID = 1'b0;
   sadbb_pkg::sadbb_req_s REQ = '0;
   logic                  FLASH_CMD_BUSY = 1'b0;
   logic                  slow = 1'b0;
   logic                  REQ_READY, RSP_VALID, SLV_VALID, SLV_LOCK, SLV_ACK, SLV_ERR;
   logic [31:0]           SLV_RDATA, x = 32'hCCE7, a, sa, d, off, ab, tb, w;
   sadbb_pkg::sadbb_rsp_s RSP;
   sadbb_pkg::sadbb_slv_s SLV_REQ;
   int                    n_errors = 0, check_count = 0, k;
   logic [33:0]           expq [$];
   logic [33:0]           e;
   logic [4:0]            b;
   // {err, master, addr}
   logic [34:0]           tbl [16] = '{{3'h0,32'h0001_FFFC}, {3'h6,32'h0002_0000},
      {3'h4,32'h0800_0000}, {3'h3,32'h1FFF_C000}, {3'h6,32'h1FFF_BFFC},
      {3'h3,32'h2000_3FFC}, {3'h4,32'h2000_4000}, {3'h6,32'h2200_0000},
      {3'h6,32'h3000_0010}, {3'h0,32'h3000_0010}, {3'h2,32'h4000_1000},
      {3'h7,32'h400F_F000}, {3'h6,32'h43FE_0000}, {3'h1,32'hE000_0000},
      {3'h6,32'hE000_E000}, {3'h7,32'h4000_2000}};
   sadbb_top i_sadbb_top (.MCLK, .RST_B, .REQ_VALID, .REQ, .REQ_READY, .RSP_VALID, .RSP,
      .FLASH_CMD_BUSY, .SLV_VALID, .SLV_LOCK, .SLV_REQ, .SLV_ACK, .SLV_ERR, .SLV_RDATA);
   sadbb_slave_model i_sadbb_slave_model (.clk(MCLK), .rst_b(RST_B), .slow(slow),
      .vld(SLV_VALID), .req(SLV_REQ), .ack(SLV_ACK), .err(SLV_ERR), .rdata(SLV_RDATA));
   always #12.5 MCLK = ~MCLK;
   function automatic logic [31:0] rnd();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   task chk(input string nm, input logic [31:0] s, input logic [31:0] ex);
      check_count++;
      if (s !== ex) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, ex, s);
      end
   endtask
   task results();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // note the expectation, then hold the request until it is taken
   task req(input logic [1:0] m, input logic wr, input logic [31:0] ad, input logic [31:0] wd,
            input logic [33:0] ex);
      int i;
      expq.push_back(ex);
      @(posedge MCLK);
      REQ_VALID <= 1'b1;
      REQ <= {sadbb_pkg::sadbb_master_e'(m), wr, ad, wd};
      for (i = 0; i < 50; i++) begin
         @(negedge MCLK);
         if (REQ_READY === 1'b1) break;
      end
      if (i == 50) begin
         n_errors++;
         results();
      end
      @(posedge MCLK);
      REQ_VALID <= 1'b0;
   endtask
   always @(negedge MCLK) begin
      if (RST_B && RSP_VALID === 1'b1) begin
         if (expq.size() == 0) chk("unexpected answer", 32'h1, 32'h0);
         else begin
            e = expq.pop_front();
            chk("err", {31'h0, RSP.err}, {31'h0, e[32]});
            if (e[33]) chk("rdata", RSP.rdata, e[31:0]);
         end
      end
   end
   initial begin
      repeat (3) @(posedge MCLK);
      RST_B <= 1'b1;
      foreach (tbl[i]) begin
         a = tbl[i][31:0];
         sa = a[31:28] == 4'h3 ? a - `SADBB_FALIAS_LO : a;
         req(tbl[i][33:32], 1'b0, a, rnd(), tbl[i][34] ? {2'b11, 32'h0} : {2'b10, sa ^ 32'h5A5A_A5A5});
      end
      req(2'h0, 1'b0, 32'h4000_0000, 32'h0, {2'b01, 32'h0});
      $display("test decode done");
      FLASH_CMD_BUSY <= 1'b1;
      req(2'h0, 1'b0, 32'h0000_0100, 32'h0, {2'b11, 32'h0});
      req(2'h2, 1'b1, 32'h0000_0100, rnd(), 34'h0);
      FLASH_CMD_BUSY <= 1'b0;
      $display("test collision done");
      for (k = 0; k < 8; k++) begin
         d = rnd();
         off = k * 32'h40 + (d & 32'h3C);
         b = d[12:8];
         // pass 1 uses bridge slot 2, clear of the slot that the slave model faults
         ab = k[1] ? `SADBB_GALIAS_LO
            : k == 1 ? `SADBB_PALIAS_LO + 32'h0004_0000 : `SADBB_SALIAS_LO;
         tb = k[1] ? `SADBB_GPIO_LO : k == 1 ? `SADBB_PB_LO + 32'h2000 : `SADBB_SRAMU_LO;
         slow <= k[0];
         w = (tb + off) ^ 32'h5A5A_A5A5;
         w[b] = d[0];
         req({1'b0, k[2]}, 1'b1, ab + off * 32 + b * 4, d, 34'h0);
         req({1'b0, k[2]}, 1'b0, ab + off * 32 + b * 4, rnd(), {2'b10, 31'h0, d[0]});
         req(2'h0, 1'b0, tb + off, 32'h0, {2'b10, w});
      end
      $display("test alias done");
      for (k = 0; k < 50 && expq.size() != 0; k++) @(posedge MCLK);
      if (expq.size() != 0) n_errors++;
      results();
   end
endmodule
